/* File: bench/asp_link_props.sv */
/*
  Link checker for the converter and receiver pair.
  Assumes every link signal is sampled on the shared core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module asp_link_props (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic mode_select_msb,
  input wire logic mode_select_lsb,
  input wire logic dev_rst_b,
  input wire logic fsc_dev_oe_b,
  input wire logic bclk_dev_oe_b,
  input wire logic sdo_dev_oe_b,
  input wire logic frame_select_clock,
  input wire logic bit_clock,
  input wire logic serial_data_out
);
  // ----------------------------------------------------------------
  // pin timing; released pins, or link reset for the slave frame, excuse a clock cut short by reset
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [1:0] mode = {mode_select_msb, mode_select_lsb};
  property p_slv; mode == 2'h3 |-> fsc_dev_oe_b && bclk_dev_oe_b; endproperty
  a_slv: assert property (p_slv) else $error("clock pin driven as slave");
  property p_rst; !dev_rst_b [*2] |-> sdo_dev_oe_b && fsc_dev_oe_b && bclk_dev_oe_b; endproperty
  a_rst: assert property (p_rst) else $error("pin driven in reset");
  property p_strap; $rose(dev_rst_b) |-> sdo_dev_oe_b [*4]; endproperty
  a_strap: assert property (p_strap) else $error("data pin driven before strap");
  // the bit seen at a rise must still stand one edge later; a released pin excuses it
  property p_hold; !sdo_dev_oe_b && !$past(sdo_dev_oe_b) && $rose(bit_clock)
    |=> $stable(serial_data_out) || sdo_dev_oe_b; endproperty
  a_hold: assert property (p_hold) else $error("data moved while being sampled");
  property p_mode; $changed(mode) |-> ##[0:2] !dev_rst_b; endproperty
  a_mode: assert property (p_mode) else $error("mode moved without reset");
  property p_bck; mode == 2'h0 && !bclk_dev_oe_b && $rose(bit_clock) |=> (bit_clock || bclk_dev_oe_b) ##1 !bit_clock;
  endproperty
  a_bck: assert property (p_bck) else $error("bit clock half period wrong");
  property p_dbl; mode == 2'h1 && !fsc_dev_oe_b && $rose(frame_select_clock)
    |-> ##63 (frame_select_clock || fsc_dev_oe_b) ##1 !frame_select_clock; endproperty
  a_dbl: assert property (p_dbl) else $error("double frame not 128");
  property p_sfs; mode == 2'h3 && $rose(frame_select_clock)
    |-> ##127 (frame_select_clock || !dev_rst_b) ##1 !frame_select_clock; endproperty
  a_sfs: assert property (p_sfs) else $error("slave frame not 256");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/*
  Self-checking bench: both ends joined by the link, one scenario per mode.
  Assumes the 250 MHz core clock is also the master clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, vld = 1'b0, en = 1'b0, fmt = 1'b0;
  logic [47:0] dat = '0;
  logic [1:0]  mode = 2'h0;
  wire logic   rdy, run, div2, rerr, fmt_o, pv;
  wire logic [1:0]  spd;
  wire logic [23:0] lft, rgt;
  int          num_errors = 0, compares = 0, cyc = 0;
  asp_link_if link();
  asp_adc_end i_asp_adc_end (.core_clk_i, .rst_b_i, .link, .sample_pair_i(dat), .sample_valid_i(vld),
    .sample_ready_o(rdy), .speed_o(spd), .mclk_div2_o(div2), .ratio_err_o(rerr), .fmt_i2s_o(fmt_o), .running_o(run));
  asp_host_end #(.RST_HOLD_CYC(2)) i_asp_host_end (.core_clk_i, .rst_b_i, .link, .mode_i(mode), .fmt_i2s_i(fmt),
    .adc_enable_i(en), .left_o(lft), .right_o(rgt), .pair_valid_o(pv));
  asp_link_props i_asp_link_props (.core_clk_i, .rst_b_i, .mode_select_msb(link.mode_select_msb),
    .mode_select_lsb(link.mode_select_lsb), .dev_rst_b(link.dev_rst_b), .fsc_dev_oe_b(link.fsc_dev_oe_b),
    .bclk_dev_oe_b(link.bclk_dev_oe_b), .sdo_dev_oe_b(link.sdo_dev_oe_b),
    .frame_select_clock(link.frame_select_clock), .bit_clock(link.bit_clock),
    .serial_data_out(link.serial_data_out));
  // ----------------------------------------------------------------
  // helpers; negative left words exercise the sign bit
  // ----------------------------------------------------------------
  function automatic logic [47:0] pr(input int i);
    return {24'h800000 + 24'(i), 24'h000010 + 24'(i)};
  endfunction
  task chk(input logic [47:0] s, input logic [47:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task close_out();
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // silent pairs may lead a run, sent before the first left slot is loaded
  task get_pair(input logic [47:0] e, input int skip);
    for (int j = 0; j <= skip; j++) begin
      if (j > 0) @(negedge core_clk_i);
      for (int k = 0; k < 1000 && pv !== 1'b1; k++) @(negedge core_clk_i);
      if ({lft, rgt} !== 48'h0) break;
    end
    chk(48'(pv), 48'h1);
    chk({lft, rgt}, e);
    @(negedge core_clk_i);
  endtask
  // one mode: fill while held in reset, release, drain until zeros
  task run_mode(input logic [1:0] m, input logic f, input int n);
    int t;
    t = 0;
    @(posedge core_clk_i);
    en <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    mode <= m;
    fmt <= f;
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk_i);
      vld <= 1'b1;
      dat <= pr(t);
      @(negedge core_clk_i);
      if (rdy === 1'b1) t++;
    end
    chk(48'(rdy), 48'(n < 32));
    chk(48'(run), 48'h0);
    @(posedge core_clk_i);
    vld <= 1'b0;
    en <= 1'b1;
    chk(48'(t), 48'(n > 32 ? 32 : n));
    for (int k = 0; k < 300 && run !== 1'b1; k++) @(negedge core_clk_i);
    chk(48'(run), 48'h1);
    chk(48'(fmt_o), 48'(f));
    for (int k = 0; k < t; k++) get_pair(pr(k), k == 0 ? 3 : 0);
    get_pair(48'h0, 0);
    chk(48'(spd), 48'(m == 2'h3 ? asp_pkg::SPD_SINGLE : m));
    chk(48'(div2), 48'(m == asp_pkg::MODE_MST_QUAD));
    chk(48'(rerr), 48'h0);
  endtask
  // ----------------------------------------------------------------
  // clock, sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    run_mode(2'h0, 1'b1, 40);
    run_mode(2'h1, 1'b0, 1);
    run_mode(2'h2, 1'b1, 1);
    run_mode(2'h3, 1'b0, 2);
    close_out();
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end
endmodule
`default_nettype wire

/* File: rtl/asp_adc_end.sv */
/*
  Converter end: sample FIFO, clock master divider, slave speed detection,
  format strap capture and the serial shifter.
  Assumes link pins are synchronous to core_clk_i, which is the master clock.
*/
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = asp_pkg::PAIR_W,
  parameter int DEPTH = asp_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  // extra pointer bit tells full from empty
  assign in_ready_o  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (in_valid_i && in_ready_o) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_valid_i_ok(out_valid_o, out_ready_i)) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  function automatic logic out_valid_i_ok(input logic v, input logic r);
    return v & r;
  endfunction
endmodule

// Operation
// - slave mode: clock pins are inputs only
// - receiver drives frame clock at sample rate
// - receiver drives bit clock at 64 frames
// - slave picks speed itself from clock ratio
// - fast clock odd rates need no support
// - accepted ratios 256/512, 128/256, 64/128
// - ratio 64 refused in slave mode
// - internal divider engages for fast master clock
// - data pin level at start picks format
// - hold reset until clocks and pins settle
// - assert reset when supplies sag
// - all converters share master and frame clocks
// - one source, reset release on common edge
// - one master converter, others slave
// - typical master clocks are supported
// - mode pins: 00,01,10 master, 11 slave
// - master makes frame and 64x bit clock
// - samples leave in two's complement
// - reset low: idle, no conversions
module asp_adc_end #(
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH,
  parameter int MCLK_HZ    = asp_pkg::MCLK_HZ_DEF
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_b_i,
  asp_link_if.device                       link,
  input  wire logic [asp_pkg::PAIR_W-1:0]  sample_pair_i,
  input  wire logic                        sample_valid_i,
  output logic                             sample_ready_o,
  output logic [1:0]                       speed_o,
  output logic                             mclk_div2_o,
  output logic                             ratio_err_o,
  output logic                             fmt_i2s_o,
  output logic                             running_o
);
  localparam int SW   = asp_pkg::SAMPLE_W;
  localparam int PAD  = asp_pkg::SLOT_W - SW;
  localparam int HALF = asp_pkg::MST_RATIO_SS / (2 * asp_pkg::BCLK_PER_FRAME) - 1;
  localparam logic FAST256 = (MCLK_HZ / asp_pkg::RATIO_256) > asp_pkg::SS_RATE_MAX_HZ;
  localparam logic FAST128 = (MCLK_HZ / asp_pkg::RATIO_128) > asp_pkg::DS_RATE_MAX_HZ;

  if (MCLK_HZ <= 0 || HALF != 1 ||
      asp_pkg::MST_RATIO_DQ / (2 * asp_pkg::BCLK_PER_FRAME) != 1) begin : g_bad_cfg
    $error("master ratios or clock rate not servable");
  end

  asp_pkg::asp_state_t            state_reg;
  logic [2:0]                     strap_cnt_reg;
  logic                           fmt_i2s_reg;
  logic                           mbclk_reg;
  logic                           mleft_reg;
  logic [5:0]                     mbit_reg;
  logic                           mhalf_reg;
  logic                           bclk_prev_reg;
  logic                           fsc_last_reg;
  logic                           fsc_c_prev_reg;
  logic                           i2s_pend_reg;
  logic [asp_pkg::SLOT_W-1:0]     shift_reg;
  logic [SW-1:0]                  right_hold_reg;
  logic [asp_pkg::PER_CNT_W-1:0]  per_cnt_reg;
  logic                           seen_reg;
  logic [1:0]                     speed_reg;
  logic                           div2_reg;
  logic                           err_reg;
  logic [asp_pkg::PAIR_W-1:0]     pop_data;
  logic                           pop_valid;
  logic [1:0]                     mode;
  logic                           slave;
  logic                           run;
  logic                           bclk_fall;
  logic                           fsc_chg;
  logic                           left_now;
  logic                           load;
  logic                           pop;
  logic                           fsc_rise;

  // ------------------------------------------------------------------
  // sample buffer; a full buffer stalls the sample source
  // ------------------------------------------------------------------
  asp_fifo #(
    .WIDTH (asp_pkg::PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (sample_pair_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (pop_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop)
  );

  assign mode  = {link.mode_select_msb, link.mode_select_lsb};
  assign slave = mode == asp_pkg::MODE_SLAVE;
  assign run   = state_reg == asp_pkg::ASP_ST_RUN;

  // ------------------------------------------------------------------
  // reset and strap sequencing
  // ------------------------------------------------------------------
  // link reset low parks the sequencer, divider and shifter idle with all pins released
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg     <= asp_pkg::ASP_ST_IDLE;
      strap_cnt_reg <= 3'h0;
      fmt_i2s_reg   <= 1'b0;
    end else if (!link.dev_rst_b) begin
      state_reg     <= asp_pkg::ASP_ST_IDLE;
      strap_cnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        asp_pkg::ASP_ST_IDLE: begin
          state_reg <= asp_pkg::ASP_ST_STRAP;
        end
        asp_pkg::ASP_ST_STRAP: begin
          strap_cnt_reg <= strap_cnt_reg + 3'h1;
          // strap has settled through the resistor before it is read
          if (strap_cnt_reg == 3'(asp_pkg::STRAP_CYC - 1)) begin
            fmt_i2s_reg <= link.serial_data_out == asp_pkg::FMT_I2S;
            state_reg   <= asp_pkg::ASP_ST_RUN;
          end
        end
        asp_pkg::ASP_ST_RUN: begin
          state_reg <= asp_pkg::ASP_ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // clock master divider
  // ------------------------------------------------------------------
  // bit clock falls and frame clock moves on the same edge
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mbclk_reg <= 1'b1;
      mleft_reg <= 1'b0;
      mbit_reg  <= 6'h3F;
      mhalf_reg <= 1'b0;
    end else if (!run || slave) begin
      mbclk_reg <= 1'b1;
      mleft_reg <= 1'b0;
      mbit_reg  <= 6'h3F;
      mhalf_reg <= 1'b0;
    end else if (mode != asp_pkg::MODE_MST_SINGLE || mhalf_reg) begin
      mhalf_reg <= 1'b0;
      mbclk_reg <= ~mbclk_reg;
      if (mbclk_reg) begin
        mbit_reg  <= mbit_reg + 6'h01;
        mleft_reg <= ~mbit_reg[5] ^ (mbit_reg[4:0] != 5'h1F);
      end
    end else begin
      mhalf_reg <= 1'b1;
    end
  end

  // clock pins stay released in slave mode
  assign link.bclk_dev      = mbclk_reg;
  assign link.bclk_dev_oe_b = slave || !run;
  assign link.fsc_dev       = fmt_i2s_reg ? ~mleft_reg : mleft_reg;
  assign link.fsc_dev_oe_b  = slave || !run;

  // ------------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------------
  assign bclk_fall = bclk_prev_reg & ~link.bit_clock;
  assign fsc_chg   = link.frame_select_clock != fsc_last_reg;
  assign left_now  = fmt_i2s_reg ? ~link.frame_select_clock : link.frame_select_clock;
  assign load      = fmt_i2s_reg ? i2s_pend_reg : fsc_chg;
  assign pop       = run & bclk_fall & load & left_now & pop_valid;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_prev_reg <= 1'b1;
      fsc_last_reg  <= 1'b0;
      i2s_pend_reg  <= 1'b0;
    end else begin
      bclk_prev_reg <= link.bit_clock;
      if (bclk_fall) begin
        fsc_last_reg <= link.frame_select_clock;
        i2s_pend_reg <= fsc_chg;
      end
    end
  end

  // an empty buffer or bad ratio sends silence rather than stale words
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg      <= '0;
      right_hold_reg <= '0;
    end else if (!run) begin
      shift_reg      <= '0;
      right_hold_reg <= '0;
    end else if (bclk_fall) begin
      if (load && left_now) begin
        shift_reg      <= {(pop_valid && !err_reg) ? pop_data[asp_pkg::PAIR_W-1 -: SW] : SW'(0),
                           PAD'(0)};
        right_hold_reg <= (pop_valid && !err_reg) ? pop_data[SW-1:0] : SW'(0);
      end else if (load) begin
        shift_reg <= {right_hold_reg, PAD'(0)};
      end else begin
        shift_reg <= {shift_reg[asp_pkg::SLOT_W-2:0], 1'b0};
      end
    end
  end

  assign link.sdo_dev      = shift_reg[asp_pkg::SLOT_W-1];
  assign link.sdo_dev_oe_b = !run;

  // ------------------------------------------------------------------
  // speed selection and internal divider
  // ------------------------------------------------------------------
  assign fsc_rise = ~fsc_c_prev_reg & link.frame_select_clock;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fsc_c_prev_reg <= 1'b0;
      per_cnt_reg    <= '0;
      seen_reg       <= 1'b0;
    end else begin
      fsc_c_prev_reg <= link.frame_select_clock;
      if (!run || !slave) begin
        per_cnt_reg <= '0;
        seen_reg    <= 1'b0;
      end else if (fsc_rise) begin
        per_cnt_reg <= asp_pkg::PER_CNT_W'(1);
        seen_reg    <= 1'b1;
      end else if (per_cnt_reg != '1) begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
    end
  end

  // the ratio alone is ambiguous; the known clock rate settles it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      speed_reg <= asp_pkg::SPD_SINGLE;
      div2_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end else if (!slave) begin
      speed_reg <= mode;
      div2_reg  <= mode == asp_pkg::MODE_MST_QUAD;
      err_reg   <= 1'b0;
    end else if (fsc_rise && seen_reg) begin
      err_reg <= 1'b0;
      if (per_cnt_reg == asp_pkg::PER_CNT_W'(asp_pkg::RATIO_512)) begin
        speed_reg <= asp_pkg::SPD_SINGLE;
        div2_reg  <= 1'b1;
      end else if (per_cnt_reg == asp_pkg::PER_CNT_W'(asp_pkg::RATIO_256)) begin
        speed_reg <= FAST256 ? asp_pkg::SPD_DOUBLE : asp_pkg::SPD_SINGLE;
        div2_reg  <= FAST256;
      end else if (per_cnt_reg == asp_pkg::PER_CNT_W'(asp_pkg::RATIO_128)) begin
        speed_reg <= FAST128 ? asp_pkg::SPD_QUAD : asp_pkg::SPD_DOUBLE;
        div2_reg  <= FAST128;
      end else begin
        err_reg <= 1'b1;
      end
    end
  end

  assign speed_o     = speed_reg;
  assign mclk_div2_o = div2_reg;
  assign ratio_err_o = err_reg;
  assign fmt_i2s_o   = fmt_i2s_reg;
  assign running_o   = run;
endmodule
`default_nettype wire

/* File: rtl/asp_host_end.sv */
/*
  Receiver end: mode pins, reset sequencing, format strap, slave clock
  generation and serial sample capture.
  Assumes the converter end shares core_clk_i as its master clock.
*/
`timescale 1ns/10ps
`default_nettype none
module asp_host_end #(
  parameter int SLAVE_RATIO  = asp_pkg::RATIO_256,
  parameter int RST_HOLD_CYC = asp_pkg::RST_HOLD_CYC
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_b_i,
  asp_link_if.host                           link,
  input  wire logic [1:0]                    mode_i,
  input  wire logic                          fmt_i2s_i,
  input  wire logic                          adc_enable_i,
  output logic [asp_pkg::SAMPLE_W-1:0]       left_o,
  output logic [asp_pkg::SAMPLE_W-1:0]       right_o,
  output logic                               pair_valid_o
);
  localparam int SW   = asp_pkg::SAMPLE_W;
  localparam int HALF = SLAVE_RATIO / (2 * asp_pkg::BCLK_PER_FRAME);

  if (SLAVE_RATIO != asp_pkg::RATIO_128 && SLAVE_RATIO != asp_pkg::RATIO_256 &&
      SLAVE_RATIO != asp_pkg::RATIO_512 || RST_HOLD_CYC < 1) begin : g_bad_cfg
    $error("slave ratio or reset hold not servable");
  end

  logic [1:0]  mode_reg;
  logic        fmt_reg;
  logic [15:0] hold_cnt_reg;
  logic        dev_rst_b_reg;
  logic [2:0]  half_cnt_reg;
  logic        bclk_reg;
  logic        left_reg;
  logic [5:0]  bit_reg;
  logic        bclk_prev_reg;
  logic        fsc_last_reg;
  logic [5:0]  pos_reg;
  logic [SW-1:0] cap_reg;
  logic [SW-1:0] left_hold_reg;
  logic [SW-1:0] left_out_reg;
  logic [SW-1:0] right_out_reg;
  logic        valid_reg;
  logic        rise;
  logic [5:0]  pos;
  logic [5:0]  bit_no;
  logic        capture;

  // ------------------------------------------------------------------
  // pins, strap and reset hold
  // ------------------------------------------------------------------
  // reset is held until pins and clocks have run a while, released on a core edge
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg      <= asp_pkg::MODE_SLAVE;
      fmt_reg       <= 1'b0;
      hold_cnt_reg  <= '0;
      dev_rst_b_reg <= 1'b0;
    end else begin
      mode_reg <= mode_i;
      fmt_reg  <= fmt_i2s_i;
      if (!adc_enable_i || mode_i != mode_reg || fmt_i2s_i != fmt_reg) begin
        hold_cnt_reg  <= '0;
        dev_rst_b_reg <= 1'b0;
      end else if (hold_cnt_reg == 16'(RST_HOLD_CYC)) begin
        dev_rst_b_reg <= 1'b1;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
    end
  end

  assign link.mode_select_msb = mode_reg[1];
  assign link.mode_select_lsb = mode_reg[0];
  assign link.dev_rst_b       = dev_rst_b_reg;
  assign link.sdo_strap       = fmt_reg;

  // ------------------------------------------------------------------
  // clocks for a slave converter, divided from the shared master clock
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      half_cnt_reg <= 3'h0;
      bclk_reg     <= 1'b1;
      left_reg     <= 1'b0;
      bit_reg      <= 6'h3F;
    end else if (mode_reg != asp_pkg::MODE_SLAVE) begin
      half_cnt_reg <= 3'h0;
      bclk_reg     <= 1'b1;
      left_reg     <= 1'b0;
      bit_reg      <= 6'h3F;
    end else if (half_cnt_reg == 3'(HALF - 1)) begin
      half_cnt_reg <= 3'h0;
      bclk_reg     <= ~bclk_reg;
      if (bclk_reg) begin
        bit_reg  <= bit_reg + 6'h01;
        left_reg <= ~bit_reg[5] ^ (bit_reg[4:0] != 5'h1F);
      end
    end else begin
      half_cnt_reg <= half_cnt_reg + 3'h1;
    end
  end

  assign link.bclk_host      = bclk_reg;
  assign link.fsc_host       = fmt_reg ? ~left_reg : left_reg;
  assign link.bclk_host_oe_b = mode_reg != asp_pkg::MODE_SLAVE;
  assign link.fsc_host_oe_b  = mode_reg != asp_pkg::MODE_SLAVE;

  // ------------------------------------------------------------------
  // sample capture on rising bit clock, whoever drives it
  // ------------------------------------------------------------------
  assign rise    = ~bclk_prev_reg & link.bit_clock;
  assign pos     = (link.frame_select_clock != fsc_last_reg) ? 6'h00 : pos_reg;
  assign bit_no  = fmt_reg ? pos - 6'h01 : pos;
  assign capture = rise && dev_rst_b_reg && (!fmt_reg || pos != 6'h00) && bit_no < 6'(SW);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_prev_reg <= 1'b1;
      fsc_last_reg  <= 1'b0;
      pos_reg       <= 6'h3F;
      cap_reg       <= '0;
      left_hold_reg <= '0;
      left_out_reg  <= '0;
      right_out_reg <= '0;
      valid_reg     <= 1'b0;
    end else begin
      bclk_prev_reg <= link.bit_clock;
      valid_reg     <= 1'b0;
      if (rise) begin
        fsc_last_reg <= link.frame_select_clock;
        pos_reg      <= (pos == 6'h3F) ? pos : pos + 6'h01;
      end
      if (capture) begin
        cap_reg <= {cap_reg[SW-2:0], link.serial_data_out};
        if (bit_no == 6'(SW - 1)) begin
          // left slot is frame clock high in left-justified, low in I2S
          if (link.frame_select_clock ^ fmt_reg) begin
            left_hold_reg <= {cap_reg[SW-2:0], link.serial_data_out};
          end else begin
            left_out_reg  <= left_hold_reg;
            right_out_reg <= {cap_reg[SW-2:0], link.serial_data_out};
            valid_reg     <= 1'b1;
          end
        end
      end
    end
  end

  assign left_o       = left_out_reg;
  assign right_o      = right_out_reg;
  assign pair_valid_o = valid_reg;
endmodule
`default_nettype wire

/* File: rtl/asp_link_if.sv */
/*
  Link between converter end and receiver end: mode pins, reset, the two
  shared clock pins and the serial data pin, with pin levels resolved here.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface asp_link_if;
  logic mode_select_msb;
  logic mode_select_lsb;
  logic dev_rst_b;
  logic fsc_dev;
  logic fsc_dev_oe_b;
  logic fsc_host;
  logic fsc_host_oe_b;
  logic bclk_dev;
  logic bclk_dev_oe_b;
  logic bclk_host;
  logic bclk_host_oe_b;
  logic sdo_dev;
  logic sdo_dev_oe_b;
  logic sdo_strap;
  logic frame_select_clock;
  logic bit_clock;
  logic serial_data_out;

  // ------------------------------------------------------------------
  // pin resolution; the strap resistor wins only while the pin is released
  // ------------------------------------------------------------------
  assign frame_select_clock = !fsc_dev_oe_b ? fsc_dev : (!fsc_host_oe_b ? fsc_host : 1'b0);
  assign bit_clock          = !bclk_dev_oe_b ? bclk_dev : (!bclk_host_oe_b ? bclk_host : 1'b0);
  assign serial_data_out    = !sdo_dev_oe_b ? sdo_dev : sdo_strap;

  modport device (
    input  mode_select_msb, mode_select_lsb, dev_rst_b,
    input  frame_select_clock, bit_clock, serial_data_out,
    output fsc_dev, fsc_dev_oe_b, bclk_dev, bclk_dev_oe_b, sdo_dev, sdo_dev_oe_b
  );
  modport host (
    output mode_select_msb, mode_select_lsb, dev_rst_b, sdo_strap,
    output fsc_host, fsc_host_oe_b, bclk_host, bclk_host_oe_b,
    input  frame_select_clock, bit_clock, serial_data_out
  );
endinterface
`default_nettype wire

/* File: rtl/asp_pkg.sv */
/*
  Shared constants for the serial audio port pair: mode pin codes, speed
  codes, frame geometry, clock ratios and timing counts.
  Assumes one core clock of 250 MHz that also serves as the master clock.
*/
package asp_pkg;
  // ------------------------------------------------------------------
  // frame geometry
  // ------------------------------------------------------------------
  localparam int SAMPLE_W       = 24;
  localparam int SLOT_W         = 32;
  localparam int BCLK_PER_FRAME = 64;
  localparam int PAIR_W         = 2 * SAMPLE_W;
  localparam int FIFO_DEPTH     = 32;

  // ------------------------------------------------------------------
  // mode pins {msb,lsb} and speed codes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_MST_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MST_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_MST_QUAD   = 2'h2;
  localparam logic [1:0] MODE_SLAVE      = 2'h3;
  localparam logic [1:0] SPD_SINGLE      = 2'h0;
  localparam logic [1:0] SPD_DOUBLE      = 2'h1;
  localparam logic [1:0] SPD_QUAD        = 2'h2;
  localparam logic       FMT_I2S         = 1'b1;

  // ------------------------------------------------------------------
  // master clock per frame ratios and sample rate limits
  // ------------------------------------------------------------------
  localparam int RATIO_512      = 512;
  localparam int RATIO_256      = 256;
  localparam int RATIO_128      = 128;
  localparam int MST_RATIO_SS   = RATIO_256;
  localparam int MST_RATIO_DQ   = RATIO_128;
  localparam int SS_RATE_MAX_HZ = 50000;
  localparam int DS_RATE_MAX_HZ = 100000;
  localparam int MCLK_HZ_DEF    = 12288000;
  localparam int PER_CNT_W      = 10;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RST_HOLD_NS    = 100;
  localparam int RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_NS       = 16;
  localparam int STRAP_CYC      = (STRAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ASP_ST_IDLE  = 3'b001,
    ASP_ST_STRAP = 3'b010,
    ASP_ST_RUN   = 3'b100
  } asp_state_t;
endpackage
